// >>> rtl/adio_top.sv
// What this block does
// - Three digital inputs readable one by one or all together.
// - Each input keeps separate rising-edge and falling-edge actions.
// - Edge event only after the new level holds for the filter time.
// - Zero filter time gives the edge event immediately.
// - Filter time accepts whole milliseconds 0 to 1000.
// - Filter time resets to zero, debouncing off.
// - Two digital outputs, each with its own selectable source.
// - General-purpose source drives the written level directly.
// - Output-enabled source: 1 when power output enabled.
// - Phase-form source: 1 for single phase, 0 for split or three.
// - Fault source: 1 while a fault is present.
// - Transient source: 1 while running, paused or stepping.
// - Program source: 1 while a program runs at steady state.
// - Remote source: 1 in remote state, 0 in local.
// - Per-output polarity: 0 passes, 1 inverts the source.
// - Actual output pin levels can be read back.
// - Remote-enable state switched on with 1, off with 0.
// - Remote-inhibit state switched on with 1, off with 0.
// - Relay-change option makes a strobe on each relay change.
// - Program-change option makes a strobe on setting changes.
// - Transient option makes a strobe at each transient start.
// - Strobe pin doubles as trigger out pulse at transient start.
`include "adio_map.svh"

module adio_top
    import adio_pkg::*;
#(
    parameter int unsigned TICK_CYC = `ADIO_TICK_CYC
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic [2:0] din,
    output logic [2:0] din_level,
    output logic [2:0] din_rise,
    output logic [2:0] din_fall,
    output logic act_valid,
    output logic [7:0] act_code,
    output logic [1:0] act_input,
    output logic act_is_fall,
    input wire logic pwr_out_enabled,
    input wire logic form_single,
    input wire logic fault_present,
    input wire adio_pkg::adio_trans_t trans_state,
    input wire logic prog_running,
    input wire logic remote_mode,
    input wire logic relay_state,
    input wire logic prog_change,
    input wire logic trans_start,
    output logic [1:0] dout,
    output logic remote_enable,
    output logic remote_inhibit,
    output logic fn_strobe
);
    import adio_pkg::*;

    localparam logic [7:0] STB_LAST = 8'(`ADIO_STROBE_CYC - 1);

    adio_state_t q;
    adio_state_t d;
    logic [5:0] status;
    logic stb_trig;

    // Selected source level before polarity
    function automatic logic src_level(input adio_src_t s, input logic gp,
                                       input logic [5:0] st);
        logic v;
        v = 1'b0;
        case (s)
            ADIO_SRC_GP: v = gp;
            ADIO_SRC_OUT_STATE: v = st[0];
            ADIO_SRC_FORM: v = st[1];
            ADIO_SRC_FAULT: v = st[2];
            ADIO_SRC_TRANSIENT: v = st[3];
            ADIO_SRC_PROGRAM: v = st[4];
            ADIO_SRC_REMOTE: v = st[5];
            default: v = 1'b0;
        endcase
        return v;
    endfunction

    // True when a register index is entry i of a run of three from a base
    function automatic logic in_run(input logic [3:0] a, input logic [3:0] base,
                                    input int i);
        return a == base + 4'(i);
    endfunction

    assign status = {remote_mode, prog_running, (trans_state != ADIO_TR_STOP),
                     fault_present, form_single, pwr_out_enabled};

    // Debounce filters
    for (genvar g = 0; g < 3; g++) begin : g_deb
        adio_debounce u_deb (
            .sys_clk(sys_clk),
            .sys_rst(sys_rst),
            .raw(din[g]),
            .tick(q.tick),
            .filt(q.filt[g]),
            .level(din_level[g]),
            .rise(din_rise[g]),
            .fall(din_fall[g])
        );
    end

    assign stb_trig = (q.stb_en[`ADIO_STB_RELAY_BIT] && relay_state != q.relay_prev) ||
                      (q.stb_en[`ADIO_STB_PROG_BIT] && prog_change) ||
                      (q.stb_en[`ADIO_STB_TRAN_BIT] && trans_start);

    always_comb begin
        d = q;
        d.tick = 1'b0;
        d.act_valid = 1'b0;
        d.relay_prev = relay_state;
        // Millisecond tick
        if (q.tick_cnt >= 18'(TICK_CYC - 1)) begin
            d.tick_cnt = 18'h00000;
            d.tick = 1'b1;
        end else begin
            d.tick_cnt = q.tick_cnt + 18'h00001;
        end

        // Register writes
        if (reg_wr) begin
            for (int i = 0; i < 3; i++) begin
                if (in_run(reg_addr, `ADIO_OFS_FILT1, i) && reg_wdata <= `ADIO_FILT_MAX) begin
                    d.filt[i] = reg_wdata[9:0];
                end
                if (in_run(reg_addr, `ADIO_OFS_ACT1, i)) begin
                    d.act[i] = reg_wdata;
                end
            end
            for (int j = 0; j < 2; j++) begin
                if (reg_addr == `ADIO_OFS_OUT1 + 4'(j) &&
                    reg_wdata[`ADIO_OCFG_SRC_MSB:`ADIO_OCFG_SRC_LSB] <= 3'(ADIO_SRC_REMOTE)) begin
                    d.ocfg[j].src =
                        adio_src_t'(reg_wdata[`ADIO_OCFG_SRC_MSB:`ADIO_OCFG_SRC_LSB]);
                    d.ocfg[j].inv = reg_wdata[`ADIO_OCFG_INV_BIT];
                    d.ocfg[j].gp = reg_wdata[`ADIO_OCFG_GP_BIT];
                end
            end
            if (reg_addr == `ADIO_OFS_REMOTE) begin
                d.rem_ena = reg_wdata[`ADIO_REM_ENA_BIT];
                d.rem_inh = reg_wdata[`ADIO_REM_INH_BIT];
            end
            if (reg_addr == `ADIO_OFS_STROBE) begin
                d.stb_en = reg_wdata[2:0];
            end
        end

        // Register reads, answered next cycle
        d.rdata = 16'h0000;
        if (reg_rd) begin
            if (reg_addr == `ADIO_OFS_IN_ALL) begin
                d.rdata = {13'h0000, din_level};
            end
            for (int i = 0; i < 3; i++) begin
                if (in_run(reg_addr, `ADIO_OFS_IN1, i)) begin
                    d.rdata = {15'h0000, din_level[i]};
                end
                if (in_run(reg_addr, `ADIO_OFS_FILT1, i)) begin
                    d.rdata = {6'h00, q.filt[i]};
                end
                if (in_run(reg_addr, `ADIO_OFS_ACT1, i)) begin
                    d.rdata = q.act[i];
                end
            end
            for (int j = 0; j < 2; j++) begin
                if (reg_addr == `ADIO_OFS_OUT1 + 4'(j)) begin
                    d.rdata = {11'h000, q.ocfg[j].gp, q.ocfg[j].inv, q.ocfg[j].src};
                end
            end
            if (reg_addr == `ADIO_OFS_OUTLVL) begin
                d.rdata = {14'h0000, q.dout};
            end
            if (reg_addr == `ADIO_OFS_REMOTE) begin
                d.rdata = {14'h0000, q.rem_inh, q.rem_ena};
            end
            if (reg_addr == `ADIO_OFS_STROBE) begin
                d.rdata = {13'h0000, q.stb_en};
            end
        end

        // Launch the configured action; lowest input first, rising before falling
        for (int i = 2; i >= 0; i--) begin
            if (din_fall[i]) begin
                d.act_valid = 1'b1;
                d.act_code = q.act[i][`ADIO_ACT_FALL_MSB:`ADIO_ACT_FALL_LSB];
                d.act_input = 2'(i);
                d.act_is_fall = 1'b1;
            end
            if (din_rise[i]) begin
                d.act_valid = 1'b1;
                d.act_code = q.act[i][`ADIO_ACT_RISE_MSB:`ADIO_ACT_RISE_LSB];
                d.act_input = 2'(i);
                d.act_is_fall = 1'b0;
            end
        end

        // Function strobe, retriggered by any new cause
        case (q.stb_st)
            ADIO_STB_IDLE: begin
                if (stb_trig) begin
                    d.stb_st = ADIO_STB_PULSE;
                    d.stb_cnt = STB_LAST;
                end
            end
            ADIO_STB_PULSE: begin
                if (stb_trig) begin
                    d.stb_cnt = STB_LAST;
                end else if (q.stb_cnt == 8'h00) begin
                    d.stb_st = ADIO_STB_IDLE;
                end else begin
                    d.stb_cnt = q.stb_cnt - 8'h01;
                end
            end
            default: begin
                d.stb_st = ADIO_STB_IDLE;
                d.stb_cnt = 8'h00;
            end
        endcase

        // Output pins
        for (int j = 0; j < 2; j++) begin
            d.dout[j] = src_level(q.ocfg[j].src, q.ocfg[j].gp, status) ^ q.ocfg[j].inv;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            q <= '0;
            q.filt <= {3{`ADIO_FILT_RST}};
            q.ocfg[0].src <= adio_src_t'(`ADIO_OUT1_SRC_RST);
            q.ocfg[1].src <= adio_src_t'(`ADIO_OUT2_SRC_RST);
            q.stb_st <= ADIO_STB_IDLE;
        end else begin
            q <= d;
        end
    end

    assign reg_rdata = q.rdata;
    assign act_valid = q.act_valid;
    assign act_code = q.act_code;
    assign act_input = q.act_input;
    assign act_is_fall = q.act_is_fall;
    assign dout = q.dout;
    assign remote_enable = q.rem_ena;
    assign remote_inhibit = q.rem_inh;
    assign fn_strobe = q.stb_st[1];

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_tran_trig;
        q.stb_en[`ADIO_STB_TRAN_BIT] && trans_start;
    endsequence

    sequence s_pulse_hold;
        fn_strobe [*8];
    endsequence

    sequence s_relay_flip;
        q.stb_en[`ADIO_STB_RELAY_BIT] && (relay_state != q.relay_prev);
    endsequence

    AST_FILT_RANGE: assert property (
        q.filt[0] <= 10'h3e8 && q.filt[1] <= 10'h3e8 && q.filt[2] <= 10'h3e8)
        else $error("filter time above limit");

    AST_FILT_RESET: assert property (disable iff (1'b0)
        $past(sys_rst) && !sys_rst |-> q.filt == '0)
        else $error("filter time not zero after reset");

    AST_RESET_SRC: assert property (disable iff (1'b0)
        $past(sys_rst) && !sys_rst |-> q.ocfg[0].src == ADIO_SRC_OUT_STATE &&
        q.ocfg[1].src == ADIO_SRC_FORM && !q.ocfg[0].inv && !q.ocfg[1].inv)
        else $error("output sources wrong after reset");

    AST_GP_LEVEL: assert property (
        q.ocfg[0].src == ADIO_SRC_GP && !q.ocfg[0].inv |=> dout[0] == $past(q.ocfg[0].gp))
        else $error("general-purpose level not driven");

    AST_FAULT_SRC: assert property (
        q.ocfg[0].src == ADIO_SRC_FAULT && !q.ocfg[0].inv |=> dout[0] == $past(fault_present))
        else $error("fault source not followed");

    AST_INVERT: assert property (
        q.ocfg[1].inv |=> dout[1] ==
        !$past(src_level(q.ocfg[1].src, q.ocfg[1].gp, status)))
        else $error("inverted output not inverted");

    AST_READBACK: assert property (
        reg_rd && reg_addr == `ADIO_OFS_OUTLVL |=> reg_rdata == {14'h0000, $past(dout)})
        else $error("output level readback wrong");

    AST_IN_ALL: assert property (
        reg_rd && reg_addr == `ADIO_OFS_IN_ALL |=> reg_rdata == {13'h0000, $past(din_level)})
        else $error("input levels readback wrong");

    AST_REM_WRITE: assert property (
        reg_wr && reg_addr == `ADIO_OFS_REMOTE |=>
        remote_enable == $past(reg_wdata[0]) && remote_inhibit == $past(reg_wdata[1]))
        else $error("remote state not written");

    AST_TRAN_STROBE: assert property (
        s_tran_trig |=> s_pulse_hold)
        else $error("transient start gave no strobe pulse");

    AST_RELAY_STROBE: assert property (
        s_relay_flip |=> fn_strobe)
        else $error("relay change gave no strobe");

    AST_NO_STROBE: assert property (
        q.stb_en == 3'h0 && !fn_strobe |=> !fn_strobe)
        else $error("strobe without enabled cause");

    AST_ACTION: assert property (
        din_rise[0] |=> act_valid && act_input == 2'h0 && !act_is_fall &&
        act_code == $past(q.act[0][7:0]))
        else $error("rising action not launched");

endmodule

// >>> rtl/adio_map.svh
`ifndef ADIO_MAP_SVH
`define ADIO_MAP_SVH

// Register offsets (word index on the plain register port)
`define ADIO_OFS_IN_ALL 4'h0
`define ADIO_OFS_IN1 4'h1
`define ADIO_OFS_FILT1 4'h4
`define ADIO_OFS_ACT1 4'h7
`define ADIO_OFS_OUT1 4'ha
`define ADIO_OFS_OUT2 4'hb
`define ADIO_OFS_OUTLVL 4'hc
`define ADIO_OFS_REMOTE 4'hd
`define ADIO_OFS_STROBE 4'he

// Output configuration fields
`define ADIO_OCFG_SRC_LSB 0
`define ADIO_OCFG_SRC_MSB 2
`define ADIO_OCFG_INV_BIT 3
`define ADIO_OCFG_GP_BIT 4

// Action code fields
`define ADIO_ACT_RISE_LSB 0
`define ADIO_ACT_RISE_MSB 7
`define ADIO_ACT_FALL_LSB 8
`define ADIO_ACT_FALL_MSB 15

// Remote and strobe fields
`define ADIO_REM_ENA_BIT 0
`define ADIO_REM_INH_BIT 1
`define ADIO_STB_RELAY_BIT 0
`define ADIO_STB_PROG_BIT 1
`define ADIO_STB_TRAN_BIT 2

// Reset values and limits
`define ADIO_FILT_MAX 16'h03e8
`define ADIO_FILT_RST 10'h000
`define ADIO_OUT1_SRC_RST 3'h1
`define ADIO_OUT2_SRC_RST 3'h2

// Timing
`define ADIO_CLK_NS 5
`define ADIO_TICK_NS 1000000
`define ADIO_TICK_CYC (`ADIO_TICK_NS / `ADIO_CLK_NS)
`define ADIO_STROBE_NS 1000
`define ADIO_STROBE_CYC ((`ADIO_STROBE_NS + `ADIO_CLK_NS - 1) / `ADIO_CLK_NS)

`endif

// >>> rtl/adio_pkg.sv
`include "adio_map.svh"

package adio_pkg;

    typedef enum logic [2:0] {
        ADIO_SRC_GP = 3'h0,
        ADIO_SRC_OUT_STATE = 3'h1,
        ADIO_SRC_FORM = 3'h2,
        ADIO_SRC_FAULT = 3'h3,
        ADIO_SRC_TRANSIENT = 3'h4,
        ADIO_SRC_PROGRAM = 3'h5,
        ADIO_SRC_REMOTE = 3'h6
    } adio_src_t;

    typedef enum logic [1:0] {
        ADIO_TR_STOP = 2'h0,
        ADIO_TR_RUN = 2'h1,
        ADIO_TR_PAUSE = 2'h2,
        ADIO_TR_STEP = 2'h3
    } adio_trans_t;

    typedef enum logic [1:0] {
        ADIO_STB_IDLE = 2'b01,
        ADIO_STB_PULSE = 2'b10
    } adio_stb_t;

    typedef struct packed {
        logic stable;
        logic raw_prev;
        logic [9:0] cnt;
        logic rise;
        logic fall;
    } adio_deb_t;

    typedef struct packed {
        adio_src_t src;
        logic inv;
        logic gp;
    } adio_ocfg_t;

    typedef struct packed {
        logic [17:0] tick_cnt;
        logic tick;
        logic [2:0][9:0] filt;
        logic [2:0][15:0] act;
        adio_ocfg_t [1:0] ocfg;
        logic rem_ena;
        logic rem_inh;
        logic [2:0] stb_en;
        logic relay_prev;
        adio_stb_t stb_st;
        logic [7:0] stb_cnt;
        logic [1:0] dout;
        logic act_valid;
        logic [7:0] act_code;
        logic [1:0] act_input;
        logic act_is_fall;
        logic [15:0] rdata;
    } adio_state_t;

endpackage

// >>> rtl/adio_debounce.sv
module adio_debounce
    import adio_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic raw,
    input wire logic tick,
    input wire logic [9:0] filt,
    output logic level,
    output logic rise,
    output logic fall
);
    import adio_pkg::*;

    adio_deb_t q;
    adio_deb_t d;

    always_comb begin
        d = q;
        d.rise = 1'b0;
        d.fall = 1'b0;
        d.raw_prev = raw;
        // Any raw change restarts the hold count
        if (raw != q.raw_prev) begin
            d.cnt = 10'h000;
        end else if (raw != q.stable && tick && q.cnt < filt) begin
            d.cnt = q.cnt + 10'h001;
        end
        // Accept once held for the filter time, or at once with zero filter
        if (raw != q.stable && (filt == 10'h000 ||
            (raw == q.raw_prev && q.cnt >= filt))) begin
            d.stable = raw;
            d.rise = raw;
            d.fall = ~raw;
            d.cnt = 10'h000;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign level = q.stable;
    assign rise = q.rise;
    assign fall = q.fall;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    AST_DEB_IMMEDIATE: assert property (
        (filt == 10'h000 && raw != q.stable) |=> (level == $past(raw)) && (rise || fall))
        else $error("zero filter did not pass the edge at once");

    AST_DEB_HOLD: assert property (
        (rise || fall) |-> ($past(filt) == 10'h000 || $past(q.cnt) >= $past(filt)))
        else $error("edge event raised before the filter time");

    AST_DEB_SHORT: assert property (
        (filt != 10'h000 && raw != q.stable && raw != q.raw_prev) |=> !(rise || fall))
        else $error("fresh transition produced an event with filter set");

endmodule

// >>> testbench/adio_switch.sv
module adio_switch (
    input wire logic sys_clk,
    output logic [2:0] din
);
    timeunit 1ns;
    timeprecision 1ps;

    // Contacts start open
    initial din = 3'h0;

    // Moves one contact just after a clock edge
    task set_pin(input int i, input logic v);
        @(posedge sys_clk);
        din[i] <= v;
    endtask

    // Short closure that drops back open, as a bouncing contact does
    task bounce(input int i, input int cyc);
        set_pin(i, 1'b1);
        repeat (cyc) @(posedge sys_clk);
        din[i] <= 1'b0;
    endtask
endmodule

// >>> testbench/test_adio_top.sv
`include "adio_map.svh"

module test_adio_top;
    timeunit 1ns;
    timeprecision 1ps;
    import adio_pkg::*;

    localparam int TICK = 20;
    logic sys_clk, sys_rst, reg_wr, reg_rd, act_valid, act_is_fall;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, rd;
    logic [2:0] din, din_level, din_rise, din_fall;
    logic [7:0] act_code;
    logic [1:0] act_input, dout;
    logic pwr_out_enabled, form_single, fault_present, prog_running, remote_mode;
    logic relay_state, prog_change, trans_start, remote_enable, remote_inhibit, fn_strobe;
    adio_trans_t trans_state;
    int err_total, compares, n;

    adio_switch i_adio_switch (.sys_clk, .din);

    adio_top #(.TICK_CYC(TICK)) i_adio_top (
        .sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .din, .din_level, .din_rise, .din_fall, .act_valid, .act_code, .act_input,
        .act_is_fall, .pwr_out_enabled, .form_single, .fault_present, .trans_state,
        .prog_running, .remote_mode, .relay_state, .prog_change, .trans_start,
        .dout, .remote_enable, .remote_inhibit, .fn_strobe
    );

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task results;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task rd_chk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask

    task settle;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask

    // Counts cycles until an edge event; a required event that never comes ends the run
    task wait_evt(input int idx, input logic fall, input int lim, input logic must);
        n = 0;
        while ((fall ? din_fall[idx] : din_rise[idx]) !== 1'b1 && n < lim) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (must && n >= lim) begin
            err_total++;
            results();
        end
    endtask

    task set_stat(input int s, input logic v);
        @(posedge sys_clk);
        case (s)
            1: pwr_out_enabled <= v;
            2: form_single <= v;
            3: fault_present <= v;
            4: trans_state <= v ? ADIO_TR_PAUSE : ADIO_TR_STOP;
            5: prog_running <= v;
            default: remote_mode <= v;
        endcase
    endtask

    task pulse(input int k);
        @(posedge sys_clk);
        case (k)
            0: relay_state <= ~relay_state;
            1: prog_change <= 1'b1;
            default: trans_start <= 1'b1;
        endcase
        @(posedge sys_clk);
        prog_change <= 1'b0;
        trans_start <= 1'b0;
        #1;
    endtask

    // Length of the next strobe in cycles, 0 if none starts
    task strobe_len;
        int w;
        n = 0;
        w = 0;
        while (fn_strobe !== 1'b1 && w < 4) begin
            @(posedge sys_clk);
            #1;
            w++;
        end
        while (fn_strobe === 1'b1 && n < 400) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
    endtask

    initial begin
        sys_rst = 1'b1;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {pwr_out_enabled, form_single, fault_present, prog_running, remote_mode} = '0;
        {relay_state, prog_change, trans_start} = '0;
        trans_state = ADIO_TR_STOP;
        err_total = 0;
        compares = 0;
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        // Reset values and an unmapped read
        rd_chk(`ADIO_OFS_FILT1, 16'h0000);
        rd_chk(`ADIO_OFS_OUT1, 16'h0001);
        rd_chk(`ADIO_OFS_OUT2, 16'h0002);
        rd_chk(4'hf, 16'h0000);
        // Filter limit accepted, one above refused
        reg_write(`ADIO_OFS_FILT1, 16'h03e8);
        rd_chk(`ADIO_OFS_FILT1, 16'h03e8);
        reg_write(`ADIO_OFS_FILT1, 16'h03e9);
        rd_chk(`ADIO_OFS_FILT1, 16'h03e8);
        reg_write(`ADIO_OFS_FILT1, 16'h0000);
        // Unfiltered input 0, both edge actions
        reg_write(`ADIO_OFS_ACT1, 16'h5aa5);
        i_adio_switch.set_pin(0, 1'b1);
        wait_evt(0, 1'b0, 20, 1'b1);
        check(16'(n <= 3), 16'h0001);
        @(posedge sys_clk);
        #1;
        check({act_valid, act_is_fall, 6'h0, act_code}, 16'h80a5);
        rd_chk(`ADIO_OFS_IN_ALL, 16'h0001);
        rd_chk(`ADIO_OFS_IN1, 16'h0001);
        rd_chk(`ADIO_OFS_IN1 + 4'h1, 16'h0000);
        i_adio_switch.set_pin(0, 1'b0);
        wait_evt(0, 1'b1, 20, 1'b1);
        @(posedge sys_clk);
        #1;
        check({act_valid, act_is_fall, 6'h0, act_code}, 16'hc05a);
        // Input 1 with 3-tick filter (tick of TICK cycles): short closure ignored, long one qualified
        reg_write(`ADIO_OFS_FILT1 + 4'h1, 16'h0003);
        reg_write(`ADIO_OFS_ACT1 + 4'h1, 16'h0033);
        i_adio_switch.bounce(1, 2 * TICK - 10);
        wait_evt(1, 1'b0, 5 * TICK, 1'b0);
        check(16'(n), 16'(5 * TICK));
        i_adio_switch.set_pin(1, 1'b1);
        wait_evt(1, 1'b0, 5 * TICK, 1'b1);
        check(16'(n >= 2 * TICK && n <= 3 * TICK + 3), 16'h0001);
        @(posedge sys_clk);
        #1;
        check({act_valid, 5'h0, act_input, act_code}, 16'h8133);
        // Output sources, inversion and readback
        reg_write(`ADIO_OFS_OUT2, 16'h0000);
        for (int s = 1; s < 7; s++) begin
            reg_write(`ADIO_OFS_OUT1, 16'(s));
            set_stat(s, 1'b0);
            settle();
            check({14'h0, dout}, 16'h0000);
            set_stat(s, 1'b1);
            settle();
            check({14'h0, dout}, 16'h0001);
            rd_chk(`ADIO_OFS_OUTLVL, 16'h0001);
            reg_write(`ADIO_OFS_OUT1, 16'(s) | 16'h0008);
            settle();
            check({14'h0, dout}, 16'h0000);
            set_stat(s, 1'b0);
        end
        reg_write(`ADIO_OFS_OUT1, 16'h0004);
        for (int t = 1; t < 4; t++) begin
            @(posedge sys_clk) trans_state <= adio_trans_t'(t);
            settle();
            check({14'h0, dout}, 16'h0001);
        end
        @(posedge sys_clk) trans_state <= ADIO_TR_STOP;
        // General-purpose levels, refused source code, second output
        reg_write(`ADIO_OFS_OUT1, 16'h0010);
        settle();
        check({14'h0, dout}, 16'h0001);
        reg_write(`ADIO_OFS_OUT1, 16'h0000);
        settle();
        check({14'h0, dout}, 16'h0000);
        reg_write(`ADIO_OFS_OUT1, 16'h0017);
        rd_chk(`ADIO_OFS_OUT1, 16'h0000);
        reg_write(`ADIO_OFS_OUT2, 16'h0003);
        set_stat(3, 1'b1);
        settle();
        check({14'h0, dout}, 16'h0002);
        rd_chk(`ADIO_OFS_OUTLVL, 16'h0002);
        // Remote enable and inhibit
        for (int v = 3; v >= 0; v--) begin
            reg_write(`ADIO_OFS_REMOTE, 16'(v));
            settle();
            check({14'h0, remote_inhibit, remote_enable}, 16'(v));
        end
        // Strobe causes, each with only its own option set, then with all others set
        for (int k = 0; k < 3; k++) begin
            reg_write(`ADIO_OFS_STROBE, 16'h0001 << k);
            pulse(k);
            strobe_len();
            check(16'(n), 16'(`ADIO_STROBE_CYC));
            reg_write(`ADIO_OFS_STROBE, 16'h0007 ^ (16'h0001 << k));
            pulse(k);
            strobe_len();
            check(16'(n), 16'h0000);
        end
        results();
    end
endmodule
